/* File: pfd_params.svh */
// Address, mode code and field constants for the pixel format decoder.
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH

// Register indices on the plain register port.
`define PFD_ADDR_MODE   4'h0
`define PFD_ADDR_STAT   4'h1
`define PFD_RD_NONE     8'h00

// Reset value and mode codes of the DAC mode register.
`define PFD_MODE_RESET  8'h00
`define PFD_CODE_PAL    8'h00
`define PFD_CODE_GRAY   8'h01
`define PFD_CODE_332    8'h02
`define PFD_CODE_555_A  8'hc0
`define PFD_CODE_555_B  8'he0
`define PFD_CODE_MIX_A  8'hd0
`define PFD_CODE_MIX_B  8'hf0
`define PFD_CLKDBL_MASK 8'hcf
`define PFD_CLKDBL_VAL  8'h4a
`define PFD_DBL_BIT     5

// Pixel word field positions.
`define PFD_SEL_BIT     15
`define PFD_R5_HI       14
`define PFD_R5_LO       10
`define PFD_G5_HI       9
`define PFD_G5_LO       5
`define PFD_B5_HI       4
`define PFD_B5_LO       0
// Byte pixel field positions: palette index and the 3-3-2 split.
`define PFD_IDX_HI      7
`define PFD_IDX_LO      0
`define PFD_R3_HI       7
`define PFD_R3_LO       5
`define PFD_G3_HI       4
`define PFD_G3_LO       2
`define PFD_B2_HI       1
`define PFD_B2_LO       0
`define PFD_HI_BYTE     8'h00
`define PFD_LSB_PAD     2'h0

`endif

/* File: pfd_pkg.sv */
// Types shared by the pixel format decoder files.
package pfd_pkg;

	// Decoded pixel interpretation.
	typedef enum logic [2:0] {
		MODE_PAL,
		MODE_GRAY,
		MODE_332,
		MODE_555,
		MODE_MIX
	} pix_mode_t;

	// One colour palette entry, six bits per gun.
	typedef struct packed {
		logic [5:0] r;
		logic [5:0] g;
		logic [5:0] b;
	} pal_entry_t;

	// One colour presented to the three DACs.
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} rgb_t;

endpackage : pfd_pkg

/* File: field_justify.sv */
// Left-justifies a narrow colour field into a DAC input byte.
`timescale 1ns/1ns
module field_justify
	import pfd_pkg::*;
#(
	parameter int W = 5
) (
	input  wire logic [W-1:0] field,
	output wire logic [7:0]   level
);

	// Low bits are zero filled; bit replication was not wanted here.
	assign level = 8'(field) << (8 - W);

endmodule : field_justify

/* File: pixel_format_decoder.sv */
// Pixel format decoder: mode register, byte pairing, palette and direct colour paths.
//
// Contract
// - Mode register zero selects palettized 8-bit mode.
// - Reset clears the mode register to zero.
// - Palette mode: byte indexes palette, entry drives DACs.
// - Grayscale: byte goes unchanged to all DACs.
// - 3-3-2: byte split directly into three fields.
// - Codes C0 or E0 select direct 5-5-5.
// - Direct 5-5-5: red high, blue low, bit15 unused.
// - Word pairs bytes: blue byte low, red byte high.
// - Codes D0 or F0 select 5-5-5 mix mode.
// - Mix, bit15 zero: lower bits are direct colour.
// - Mix, bit15 one: bits 7:0 index the palette.
// - Mode bit 5 doubles pixels in 16-bit modes.
// - Palette clock doubling code 01xx1010 is unsupported.
`timescale 1ns/1ns
`include "pfd_params.svh"
module pixel_format_decoder
	import pfd_pkg::*;
(
	input  wire logic       clk_sys,        // System clock, 25 MHz.
	input  wire logic       reset_n,        // Asynchronous reset, active low.
	input  wire logic [3:0] reg_addr,       // Register index.
	input  wire logic [7:0] reg_wdata,      // Register write data.
	input  wire logic       reg_wr,         // Write strobe, one cycle.
	input  wire logic       reg_rd,         // Read strobe, one cycle.
	output logic      [7:0] reg_rdata,      // Read data, the cycle after the strobe.
	input  wire logic       pix_valid,      // One display memory byte this cycle.
	input  wire logic [7:0] pix_data,       // Display memory byte.
	input  wire logic       pix_line_start, // This byte sits on an even address.
	output logic            pal_rd,         // Palette read request.
	output logic      [7:0] pal_index,      // Palette address.
	input  wire pal_entry_t pal_entry,      // Palette answer, same cycle as pal_rd.
	output logic            dac_valid,      // One colour for the DACs.
	output rgb_t            dac_rgb         // Colour to the DACs.
);

	// DAC mode register as software wrote it.
	logic [7:0] dac_mode_register_r;
	// Byte phase inside a 16-bit pixel: one means the low byte is held.
	logic       phase_r;
	// Held low (blue) byte of a 16-bit pixel.
	logic [7:0] lo_r;
	// Stage one: a pixel word with its interpretation.
	logic       s1_valid_r;
	logic [15:0] s1_word_r;
	pix_mode_t  s1_mode_r;
	logic       s1_dbl_r;
	// Palette request registers.
	logic       pal_rd_r;
	logic [7:0] pal_index_r;
	// Output stage.
	logic       rep_r;
	logic       dac_valid_r;
	rgb_t       dac_rgb_r;
	logic [7:0] reg_rdata_r;

	// Decoded interpretation of the current mode register.
	pix_mode_t  cur_mode;
	// Pixel doubling request from the mode register.
	logic       dbl_bit;
	// The register holds the unsupported palette clock doubling code.
	logic       clkdbl_code;
	// Current mode fetches two bytes per pixel.
	logic       wide_mode;
	// A whole pixel word is complete this cycle.
	logic       word_fire;
	logic [15:0] word_in;
	// Mode register write this cycle.
	logic       mode_wr;

	// Maps a register code onto a pixel interpretation.
	function automatic pix_mode_t decode_mode(input logic [7:0] code);
		pix_mode_t m;
		m = MODE_PAL;
		if (code == `PFD_CODE_555_A || code == `PFD_CODE_555_B) begin
			m = MODE_555;
		end else if (code == `PFD_CODE_MIX_A || code == `PFD_CODE_MIX_B) begin
			m = MODE_MIX;
		end else if (code == `PFD_CODE_GRAY) begin
			m = MODE_GRAY;
		end else if (code == `PFD_CODE_332) begin
			m = MODE_332;
		end
		// clock doubling ignored
		// Zero, the clock doubling code and unknown codes all fall to palette.
		return m;
	endfunction : decode_mode

	assign cur_mode    = decode_mode(dac_mode_register_r);
	assign dbl_bit     = dac_mode_register_r[`PFD_DBL_BIT];
	assign clkdbl_code = (dac_mode_register_r & `PFD_CLKDBL_MASK) == `PFD_CLKDBL_VAL;
	assign wide_mode   = (cur_mode == MODE_555) || (cur_mode == MODE_MIX);
	assign mode_wr     = reg_wr && (reg_addr == `PFD_ADDR_MODE);

	// Mode register; software writes it at any time.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dac_mode_register_r <= `PFD_MODE_RESET;
		end else if (mode_wr) begin
			dac_mode_register_r <= reg_wdata;
		end
	end

	// Register reads answer one cycle later and read zero otherwise.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_r <= `PFD_RD_NONE;
		end else if (reg_rd && reg_addr == `PFD_ADDR_MODE) begin
			reg_rdata_r <= dac_mode_register_r;
		end else if (reg_rd && reg_addr == `PFD_ADDR_STAT) begin
			// Status shows the live decode so software can see what took effect.
			reg_rdata_r <= {1'b0, clkdbl_code, dbl_bit && wide_mode, phase_r,
				1'b0, 3'(cur_mode)};
		end else begin
			reg_rdata_r <= `PFD_RD_NONE;
		end
	end

	// byte pairing order
	// The low address byte holds blue and arrives first.
	assign word_fire = pix_valid && (!wide_mode || (phase_r && !pix_line_start));
	assign word_in   = wide_mode ? {pix_data, lo_r} : {`PFD_HI_BYTE, pix_data};

	// Byte phase tracker; a line start realigns so an odd byte can never
	// leave the pairing skewed past the next line start.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= 1'b0;
			lo_r    <= `PFD_HI_BYTE;
		end else if (mode_wr) begin
			// A mode change drops any half pixel.
			phase_r <= 1'b0;
		end else if (pix_valid && wide_mode) begin
			if (pix_line_start || !phase_r) begin
				phase_r <= 1'b1;
				lo_r    <= pix_data;
			end else begin
				phase_r <= 1'b0;
			end
		end else if (!wide_mode) begin
			phase_r <= 1'b0;
		end
	end

	// Stage one captures the word and its interpretation.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1_valid_r <= 1'b0;
			s1_word_r  <= 16'h0000;
			s1_mode_r  <= MODE_PAL;
			s1_dbl_r   <= 1'b0;
		end else begin
			s1_valid_r <= word_fire;
			if (word_fire) begin
				s1_word_r <= word_in;
				s1_mode_r <= cur_mode;
				s1_dbl_r  <= dbl_bit && wide_mode;
			end
		end
	end

	// Palette requests go out beside stage one; the entry is used in that same cycle.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pal_rd_r    <= 1'b0;
			pal_index_r <= 8'h00;
		end else begin
			// mix palette index
			// Bit 15 selects the palette in mix mode; bits 14:8 are dropped.
			pal_rd_r <= word_fire && ((cur_mode == MODE_PAL) ||
				(cur_mode == MODE_MIX && word_in[`PFD_SEL_BIT]));
			if (word_fire) begin
				pal_index_r <= word_in[`PFD_IDX_HI:`PFD_IDX_LO];
			end
		end
	end

	assign pal_rd    = pal_rd_r;
	assign pal_index = pal_index_r;

	// Justified colour candidates for each path.
	logic [7:0] pal_lvl [3];
	logic [7:0] d5_lvl  [3];
	logic [7:0] r332_lvl;
	logic [7:0] g332_lvl;
	logic [7:0] b332_lvl;
	logic [5:0] pal_f   [3];
	logic [4:0] d5_f    [3];

	assign pal_f[0] = pal_entry.r;
	assign pal_f[1] = pal_entry.g;
	assign pal_f[2] = pal_entry.b;
	// red high blue low
	// Bit 15 is left out here, so direct colour never depends on it.
	assign d5_f[0]  = s1_word_r[`PFD_R5_HI:`PFD_R5_LO];
	assign d5_f[1]  = s1_word_r[`PFD_G5_HI:`PFD_G5_LO];
	assign d5_f[2]  = s1_word_r[`PFD_B5_HI:`PFD_B5_LO];

	// One justifier per gun for palette and direct paths.
	for (genvar c = 0; c < 3; c++) begin : g_gun
		field_justify #(.W(6)) u_pal (
			.field (pal_f[c]),
			.level (pal_lvl[c])
		);
		field_justify #(.W(5)) u_d5 (
			.field (d5_f[c]),
			.level (d5_lvl[c])
		);
	end

	field_justify #(.W(3)) u_r332 (
		.field (s1_word_r[`PFD_R3_HI:`PFD_R3_LO]),
		.level (r332_lvl)
	);
	field_justify #(.W(3)) u_g332 (
		.field (s1_word_r[`PFD_G3_HI:`PFD_G3_LO]),
		.level (g332_lvl)
	);
	field_justify #(.W(2)) u_b332 (
		.field (s1_word_r[`PFD_B2_HI:`PFD_B2_LO]),
		.level (b332_lvl)
	);

	// Colour chosen from stage one and the palette answer.
	rgb_t colour_nxt;

	always_comb begin
		colour_nxt = dac_rgb_r;
		case (s1_mode_r)
			MODE_PAL:  colour_nxt = '{pal_lvl[0], pal_lvl[1], pal_lvl[2]};
			MODE_GRAY: colour_nxt = {3{s1_word_r[`PFD_IDX_HI:`PFD_IDX_LO]}};
			MODE_332:  colour_nxt = '{r332_lvl, g332_lvl, b332_lvl};
			MODE_555:  colour_nxt = '{d5_lvl[0], d5_lvl[1], d5_lvl[2]};
			MODE_MIX: begin
				if (!s1_word_r[`PFD_SEL_BIT]) begin
					colour_nxt = '{d5_lvl[0], d5_lvl[1], d5_lvl[2]};
				end else begin
					colour_nxt = '{pal_lvl[0], pal_lvl[1], pal_lvl[2]};
				end
			end
			// An unknown interpretation holds the last colour.
			default:   colour_nxt = dac_rgb_r;
		endcase
	end

	// Output stage; a doubled pixel repeats the held colour for one cycle,
	// which fits because a 16-bit word needs two byte cycles anyway.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dac_valid_r <= 1'b0;
			dac_rgb_r   <= '0;
			rep_r       <= 1'b0;
		end else begin
			rep_r       <= s1_valid_r && s1_dbl_r;
			dac_valid_r <= s1_valid_r || rep_r;
			if (s1_valid_r) begin
				dac_rgb_r <= colour_nxt;
			end
		end
	end

	assign dac_valid = dac_valid_r;
	assign dac_rgb   = dac_rgb_r;
	assign reg_rdata = reg_rdata_r;

	reset_mode_a: assert property (@(posedge clk_sys)
		(reset_n && !$past(reset_n)) |-> dac_mode_register_r == `PFD_MODE_RESET)
		else $error("mode register not zero after reset");
	zero_palette_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(dac_mode_register_r == `PFD_CODE_PAL && pix_valid) |=> pal_rd_r)
		else $error("zero mode did not request the palette");
	pal_lookup_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s1_valid_r && s1_mode_r == MODE_PAL) |=>
		dac_valid_r && dac_rgb_r.g == {$past(pal_entry.g), `PFD_LSB_PAD})
		else $error("palette entry not passed to the DACs");
	gray_copy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(pix_valid && cur_mode == MODE_GRAY && !mode_wr) |-> ##2
		dac_rgb_r.r == $past(pix_data, 2) && dac_rgb_r.b == $past(pix_data, 2))
		else $error("gray byte not on all DACs");
	split_332_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(pix_valid && cur_mode == MODE_332 && !mode_wr) |-> ##2
		dac_rgb_r.r[7:5] == $past(pix_data[7:5], 2) &&
		dac_rgb_r.b[7:6] == $past(pix_data[1:0], 2) && !$past(pal_rd_r))
		else $error("3-3-2 split wrong");
	direct_code_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(mode_wr && (reg_wdata == `PFD_CODE_555_A || reg_wdata == `PFD_CODE_555_B)) |=>
		cur_mode == MODE_555)
		else $error("direct code not decoded");
	mix_code_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(mode_wr && (reg_wdata == `PFD_CODE_MIX_A || reg_wdata == `PFD_CODE_MIX_B)) |=>
		cur_mode == MODE_MIX)
		else $error("mix code not decoded");
	pair_order_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(pix_valid && wide_mode && phase_r && !pix_line_start && !mode_wr) |=>
		s1_valid_r && s1_word_r == {$past(pix_data), $past(lo_r)})
		else $error("byte pairing order wrong");
	direct_555_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s1_valid_r && s1_mode_r == MODE_555) |=>
		dac_rgb_r.r[7:3] == $past(s1_word_r[14:10]) &&
		dac_rgb_r.b[7:3] == $past(s1_word_r[4:0]))
		else $error("direct 5-5-5 colour wrong");
	mix_direct_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s1_valid_r && s1_mode_r == MODE_MIX && !s1_word_r[15]) |->
		!pal_rd_r ##1 dac_rgb_r.g[7:3] == $past(s1_word_r[9:5]))
		else $error("mix direct pixel wrong");
	mix_index_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s1_valid_r && s1_mode_r == MODE_MIX && s1_word_r[15]) |->
		pal_rd_r && pal_index_r == s1_word_r[7:0])
		else $error("mix palette index wrong");
	pixel_double_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s1_valid_r && s1_dbl_r) |=> dac_valid_r ##1 (dac_valid_r && $stable(dac_rgb_r)))
		else $error("doubled pixel not repeated");
	clk_double_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clkdbl_code |-> cur_mode == MODE_PAL)
		else $error("clock doubling code changed the mode");

endmodule : pixel_format_decoder

/* File: palette_model.sv */
// Behavioural model of the colour palette that answers the decoder's lookups.
`timescale 1ns/1ns
module palette_model
	import pfd_pkg::*;
(
	input  wire logic       pal_rd,    // Palette read request from the decoder.
	input  wire logic [7:0] pal_index, // Palette address from the decoder.
	output pal_entry_t      pal_entry  // Entry returned in the same cycle.
);

	pal_entry_t entry; // Stored content, a fixed function of the address.

	// Contents are derived from the address so the bench can predict every entry.
	// six-bit entries.
	always_comb begin
		entry.r = pal_index[7:2];
		entry.g = pal_index[5:0];
		entry.b = ~pal_index[5:0];
		// Outside a read the lines carry the inverse, so a late sample cannot pass.
		if (pal_rd) begin
			pal_entry = entry;
		end else begin
			pal_entry = ~entry;
		end
	end

endmodule : palette_model

/* File: pixel_format_decoder_test.sv */
// Self-checking testbench for the pixel format decoder and its palette.
`timescale 1ns/1ns
`include "pfd_params.svh"
module pixel_format_decoder_test
	import pfd_pkg::*;
;

	logic       clk_sys;        // System clock.
	logic       reset_n;        // Reset, active low.
	logic [3:0] reg_addr;       // Register index.
	logic [7:0] reg_wdata;      // Register write data.
	logic       reg_wr;         // Write strobe.
	logic       reg_rd;         // Read strobe.
	logic [7:0] reg_rdata;      // Read data.
	logic       pix_valid;      // Pixel byte strobe.
	logic [7:0] pix_data;       // Pixel byte.
	logic       pix_line_start; // Even address marker.
	logic       pal_rd;         // Palette read request.
	logic [7:0] pal_index;      // Palette address.
	pal_entry_t pal_entry;      // Palette answer.
	logic       dac_valid;      // Colour strobe.
	rgb_t       dac_rgb;        // Colour to the DACs.
	int         num_errors;     // Mismatches seen.
	int         total_checks;   // Comparisons made.
	int         dac_cnt;        // Colour pulses since the last check.
	int         pal_cnt;        // Palette reads since the last check.
	rgb_t       last_rgb;       // Colour seen at the last pulse.
	logic [7:0] last_idx;       // Address seen at the last palette read.
	logic [7:0] codes [4];      // Sixteen-bit mode codes under test.
	logic [7:0] code;           // Code of the current pass.
	logic [7:0] dbl_codes [2];  // Unsupported clock doubling codes.

	pixel_format_decoder i_dut (
		.clk_sys        (clk_sys),
		.reset_n        (reset_n),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.pix_valid      (pix_valid),
		.pix_data       (pix_data),
		.pix_line_start (pix_line_start),
		.pal_rd         (pal_rd),
		.pal_index      (pal_index),
		.pal_entry      (pal_entry),
		.dac_valid      (dac_valid),
		.dac_rgb        (dac_rgb)
	);

	palette_model i_palette (
		.pal_rd    (pal_rd),
		.pal_index (pal_index),
		.pal_entry (pal_entry)
	);

	// Clock generator, 40 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Monitor counts colour pulses and palette reads as the edge samples them.
	always @(posedge clk_sys) begin
		if (dac_valid === 1'b1) begin
			dac_cnt = dac_cnt + 1;
			last_rgb = dac_rgb;
		end
		if (pal_rd === 1'b1) begin
			pal_cnt = pal_cnt + 1;
			last_idx = pal_index;
		end
	end

	// Expected colour of a palette pixel, from the model's fixed contents.
	function automatic rgb_t exp_pal(input logic [7:0] i);
		exp_pal = '{r: {i[7:2], 2'h0}, g: {i[5:0], 2'h0}, b: {~i[5:0], 2'h0}};
	endfunction : exp_pal

	// Expected colour of a direct word; bit 15 plays no part.
	function automatic rgb_t exp555(input logic [15:0] w);
		exp555 = '{r: {w[14:10], 3'h0}, g: {w[9:5], 3'h0}, b: {w[4:0], 3'h0}};
	endfunction : exp555

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// Compares one byte wide result.
	task automatic compare8(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask : compare8

	// Compares one colour.
	task automatic compare_rgb(input string what, input rgb_t exp, input rgb_t got);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask : compare_rgb

	// One cycle write strobe beside address and data.
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : reg_write

	// One cycle read strobe; data stands only in the following cycle.
	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		compare8("read data", exp, reg_rdata);
		@(posedge clk_sys);
		#1;
		compare8("read data after", 8'h00, reg_rdata);
	endtask : reg_read

	// Sends one byte, or two back to back when two is set.
	task automatic send(input logic [7:0] lo, input logic [7:0] hi, input bit two, input bit mark);
		@(posedge clk_sys);
		pix_valid      <= 1'b1;
		pix_data       <= lo;
		pix_line_start <= mark;
		if (two) begin
			@(posedge clk_sys);
			pix_data       <= hi;
			pix_line_start <= 1'b0;
		end
		@(posedge clk_sys);
		pix_valid      <= 1'b0;
		pix_line_start <= 1'b0;
	endtask : send

	// Lets the pipeline drain, then checks pulse counts, colour and palette address.
	task automatic expect_pix(input rgb_t exp, input int ndac, input int npal, input logic [7:0] idx);
		repeat (6) @(posedge clk_sys);
		#1;
		compare8("colour pulses", 8'(ndac), 8'(dac_cnt));
		compare8("palette reads", 8'(npal), 8'(pal_cnt));
		if (ndac != 0) compare_rgb("colour", exp, last_rgb);
		if (npal != 0) compare8("palette index", idx, last_idx);
		dac_cnt = 0;
		pal_cnt = 0;
	endtask : expect_pix

	// Watchdog; the tests need well under a thousand cycles.
	initial begin
		#(40 * 20000);
		num_errors++;
		close_out();
	end

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pix_valid = 1'b0;
		pix_data = 8'h00;
		pix_line_start = 1'b0;
		num_errors = 0;
		total_checks = 0;
		dac_cnt = 0;
		pal_cnt = 0;
		codes = '{`PFD_CODE_555_A, `PFD_CODE_555_B, `PFD_CODE_MIX_A, `PFD_CODE_MIX_B};
		dbl_codes = '{8'h4a, 8'h7a};
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		reg_read(`PFD_ADDR_MODE, `PFD_MODE_RESET);
		reg_read(`PFD_ADDR_STAT, 8'h00);
		// Two palette bytes back to back give two lookups.
		send(8'h5a, 8'hc3, 1'b1, 1'b0);
		expect_pix(exp_pal(8'hc3), 2, 2, 8'hc3);
		reg_write(`PFD_ADDR_MODE, `PFD_CODE_GRAY);
		reg_read(`PFD_ADDR_STAT, 8'h01);
		send(8'h9c, 8'h00, 1'b0, 1'b0);
		expect_pix('{r: 8'h9c, g: 8'h9c, b: 8'h9c}, 1, 0, 8'h00);
		reg_write(`PFD_ADDR_MODE, `PFD_CODE_332);
		reg_read(`PFD_ADDR_STAT, 8'h02);
		send(8'hb6, 8'h00, 1'b0, 1'b0);
		expect_pix('{r: 8'ha0, g: 8'ha0, b: 8'h80}, 1, 0, 8'h00);
		// Each sixteen-bit code; a stray byte is dropped by a marker or a mode write.
		for (int i = 0; i < 4; i++) begin
			code = codes[i];
			reg_write(`PFD_ADDR_MODE, code);
			reg_read(`PFD_ADDR_MODE, code);
			send(8'h11, 8'h00, 1'b0, 1'b0);
			reg_read(`PFD_ADDR_STAT, {2'h0, code[5], 2'h2, code[4] ? 3'h4 : 3'h3});
			if (i[0]) reg_write(`PFD_ADDR_MODE, code);
			// Direct words keep bit 15 at zero.
			send(8'h5c, 8'h7a, 1'b1, !i[0]);
			expect_pix(exp555(16'h7a5c), code[5] ? 2 : 1, 0, 8'h00);
			if (code[4]) begin
				send(8'h3c, 8'hff, 1'b1, 1'b0);
				expect_pix(exp_pal(8'h3c), code[5] ? 2 : 1, 1, 8'h3c);
			end
		end
		// Clock doubling codes fall back to palette mode and are flagged.
		foreach (dbl_codes[k]) begin
			reg_write(`PFD_ADDR_MODE, dbl_codes[k]);
			reg_read(`PFD_ADDR_STAT, 8'h40);
			send(8'h5a, 8'h00, 1'b0, 1'b0);
			expect_pix(exp_pal(8'h5a), 1, 1, 8'h5a);
		end
		// Unmapped and read-only places ignore writes.
		reg_write(4'h7, 8'hc0);
		reg_read(4'h7, 8'h00);
		reg_write(`PFD_ADDR_STAT, 8'hff);
		reg_read(`PFD_ADDR_MODE, 8'h7a);
		reg_read(`PFD_ADDR_STAT, 8'h40);
		// A second reset in mid-run clears the mode again.
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		reg_read(`PFD_ADDR_MODE, `PFD_MODE_RESET);
		close_out();
	end

endmodule : pixel_format_decoder_test
